// file: hdl/dspma_pkg.sv
// Constants shared by the multiply-add datapath and its fabric controller.
// Assumes one clock domain and an AHB-Lite master on the controller side.
package dspma_pkg;
    // Datapath widths
    localparam int OP_W = 18;
    localparam int NAR_OP_W = 9;
    localparam int LANES = 4;
    localparam int PROD_W = 38;
    localparam int RES_W = 42;
    localparam int NAR_W = 21;
    localparam int RES_WORDS = 2;
    localparam int ADDSUB_W = 4;
    // Q1.15 saturation and rounding
    localparam logic [PROD_W-1:0] SAT_TRIP = 38'h40000000;
    localparam logic [PROD_W-1:0] SAT_MAX = 38'h3fffffff;
    localparam logic [RES_W-1:0] ROUND_HALF = 42'h4000;
    localparam logic [RES_W-1:0] ROUND_MASK = 42'h3ffffff8000;
    ////////////////////////////////////////////////////////////////////////////
    // Bus constants
    localparam int ADDR_W = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_GO = 8'h04;
    localparam logic [ADDR_W-1:0] A_SHIFT = 8'h08;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] A_OPA = 8'h10;
    localparam logic [ADDR_W-1:0] A_OPB = 8'h20;
    localparam logic [ADDR_W-1:0] A_RES = 8'h30;
    // Control register fields
    localparam int CB_NARROW = 0;
    localparam int CB_FOUR = 1;
    localparam int CB_CHAIN = 2;
    localparam int CB_CREG = 3;
    localparam int CB_PIPE2 = 4;
    localparam int CB_SIGNA = 5;
    localparam int CB_SIGNB = 6;
    localparam int CB_SAT = 7;
    localparam int CB_ROUND = 8;
    localparam int CB_ADDSUB = 9;
    localparam int CTRL_W = 13;
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0;
    // Status register fields
    localparam int SB_DONE = 0;
    localparam int SB_SAT = 1;
endpackage : dspma_pkg

// file: hdl/dspma_if.sv
// Link between the multiply-add datapath and the fabric logic that feeds it.
// Assumes both ends run on the same hclk and hresetn.
interface dspma_if
    import dspma_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn
);
    // Operands and controls from fabric
    logic [LANES-1:0][OP_W-1:0] oper_a;
    logic [LANES-1:0][OP_W-1:0] oper_b;
    logic oper_valid;
    logic sign_a;
    logic sign_b;
    logic saturate_enable;
    logic [ADDSUB_W-1:0] add_sub_select;
    logic round_enable;
    logic [OP_W-1:0] shift_chain_in_a;
    // Static configuration from fabric
    logic narrow_mode;
    logic four_mult_mode;
    logic chain_enable;
    logic ctrl_reg_enable;
    logic ctl_pipe_two;
    // Results to fabric
    logic [RES_WORDS-1:0][RES_W-1:0] result;
    logic result_valid;
    logic [LANES-1:0] product_saturated_flag;
    logic [OP_W-1:0] shift_chain_out_a;

    modport dev (
        input hclk, hresetn, oper_a, oper_b, oper_valid, sign_a, sign_b,
        input saturate_enable, add_sub_select, round_enable, shift_chain_in_a,
        input narrow_mode, four_mult_mode, chain_enable, ctrl_reg_enable, ctl_pipe_two,
        output result, result_valid, product_saturated_flag, shift_chain_out_a
    );
    modport fab (
        input hclk, hresetn, result, result_valid, product_saturated_flag,
        input shift_chain_out_a,
        output oper_a, oper_b, oper_valid, sign_a, sign_b, saturate_enable,
        output add_sub_select, round_enable, shift_chain_in_a,
        output narrow_mode, four_mult_mode, chain_enable, ctrl_reg_enable, ctl_pipe_two
    );
endinterface : dspma_if

// file: hdl/dspma_device.sv
// Multiply-add datapath: four 18x18 or eight 9x9 multipliers, adder stages,
// Q1.15 rounding and saturation, and an input shift chain for FIR use.
// Assumes configuration stays steady while data flows.
//
// Contract
// - Products feed two- or four-product adders
// - Adder reachable only through multipliers
// - Four 9-bit or two 18-bit adders
// - Each adder sums or subtracts, selectable dynamically
// - Adder controls delayed one or two stages
// - Multiplier controls unregistered or registered once
// - Saturation flag aligned with result data
// - One 18-bit or two 9-bit complex multiplies
// - Real part subtracts, imaginary part adds
// - Eight 9-bit multipliers feed four adders
// - Fabric places complex components on inputs
// - One 18-bit or two 9-bit four-product adders
// - Four-product sum in two adder stages
// - Round and saturate only signed 18-bit
// - Fabric pipelines adder controls in four-product use; dspma_host drives them straight from ctrl, unpipelined
// - Operand A registers chain as shift register
// - Chain holds samples, loaded registers coefficients
// - 36-bit mode shifting done outside block
// - Four-tap 18-bit FIR; cascade outside
// - Per-operand signed or unsigned multiplication
// - Sign selects dynamic and optionally registered
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
module dspma_device
    import dspma_pkg::*;
(
    // Link to fabric
    dspma_if.dev link
);
    ////////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic signed [PROD_W-1:0] mul_ext(
        input logic [OP_W-1:0] x,
        input logic [OP_W-1:0] y,
        input logic sx,
        input logic sy,
        input logic nine
    );
        logic signed [OP_W:0] ex;
        logic signed [OP_W:0] ey;
        ex = nine ? {{(OP_W-NAR_OP_W+1){sx & x[NAR_OP_W-1]}}, x[NAR_OP_W-1:0]}
                  : {sx & x[OP_W-1], x};
        ey = nine ? {{(OP_W-NAR_OP_W+1){sy & y[NAR_OP_W-1]}}, y[NAR_OP_W-1:0]}
                  : {sy & y[OP_W-1], y};
        mul_ext = ex * ey;
    endfunction : mul_ext

    function automatic logic signed [RES_W-1:0] add_sub(
        input logic signed [PROD_W-1:0] p,
        input logic signed [PROD_W-1:0] q,
        input logic sub
    );
        add_sub = sub ? RES_W'(p) - RES_W'(q) : RES_W'(p) + RES_W'(q);
    endfunction : add_sub

    function automatic logic [RES_W-1:0] q15_round(input logic [RES_W-1:0] v);
        q15_round = (v + ROUND_HALF) & ROUND_MASK;
    endfunction : q15_round

    ////////////////////////////////////////////////////////////////////////////
    // Input registers and shift chain
    logic [LANES-1:0][OP_W-1:0] reg_a;
    logic [LANES-1:0][OP_W-1:0] reg_b;
    logic in_valid;

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            reg_a <= '0;
        end else if (link.oper_valid) begin
            if (link.chain_enable) begin
                reg_a <= {reg_a[LANES-2:0], link.shift_chain_in_a};
            end else begin
                reg_a <= link.oper_a;
            end
        end
    end

    assign link.shift_chain_out_a = reg_a[LANES-1];

    ////////////////////////////////////////////////////////////////////////////
    // Multiplier-stage controls
    logic reg_sign_a;
    logic reg_sign_b;
    logic reg_sat;
    logic use_sign_a;
    logic use_sign_b;
    logic use_sat;

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            reg_sign_a <= 1'b0;
            reg_sign_b <= 1'b0;
            reg_sat <= 1'b0;
            reg_b <= '0;
        end else if (link.oper_valid) begin
            reg_b <= link.oper_b;
            reg_sign_a <= link.sign_a;
            reg_sign_b <= link.sign_b;
            reg_sat <= link.saturate_enable;
        end
    end

    assign use_sign_a = link.ctrl_reg_enable ? reg_sign_a : link.sign_a;
    assign use_sign_b = link.ctrl_reg_enable ? reg_sign_b : link.sign_b;
    assign use_sat = link.ctrl_reg_enable ? reg_sat : link.saturate_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Multipliers and product pipeline register
    logic [LANES-1:0][PROD_W-1:0] next_wide;
    logic [2*LANES-1:0][PROD_W-1:0] next_nar;
    logic [LANES-1:0] next_sat;
    logic q15_ok;
    logic [LANES-1:0][PROD_W-1:0] prod_wide;
    logic [2*LANES-1:0][PROD_W-1:0] prod_nar;
    logic [LANES-1:0] prod_sat;
    logic prod_q15;
    logic prod_valid;

    assign q15_ok = use_sign_a && use_sign_b && !link.narrow_mode;

    always_comb begin
        for (int k = 0; k < LANES; k++) begin
            next_wide[k] = mul_ext(reg_a[k], reg_b[k], use_sign_a, use_sign_b, 1'b0);
            next_nar[2*k] = mul_ext(reg_a[k], reg_b[k], use_sign_a, use_sign_b, 1'b1);
            next_nar[2*k+1] = mul_ext(reg_a[k] >> NAR_OP_W, reg_b[k] >> NAR_OP_W,
                                      use_sign_a, use_sign_b, 1'b1);
            next_sat[k] = 1'b0;
            if (use_sat && q15_ok && next_wide[k] == SAT_TRIP) begin
                next_wide[k] = SAT_MAX;
                next_sat[k] = 1'b1;
            end
        end
    end

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            prod_wide <= '0;
            prod_nar <= '0;
            prod_sat <= '0;
            prod_q15 <= 1'b0;
            in_valid <= 1'b0;
            prod_valid <= 1'b0;
        end else begin
            prod_wide <= next_wide;
            prod_nar <= next_nar;
            prod_sat <= next_sat;
            prod_q15 <= q15_ok;
            in_valid <= link.oper_valid;
            prod_valid <= in_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Adder-stage control delay
    logic [ADDSUB_W:0] ctl_d1;
    logic [ADDSUB_W:0] ctl_d2;
    logic [ADDSUB_W:0] ctl_use;

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            ctl_d1 <= '0;
            ctl_d2 <= '0;
        end else begin
            ctl_d1 <= {link.round_enable, link.add_sub_select};
            ctl_d2 <= ctl_d1;
        end
    end

    assign ctl_use = link.ctl_pipe_two ? ctl_d2 : ctl_d1;

    ////////////////////////////////////////////////////////////////////////////
    // Adders, summation and output register
    logic [LANES-1:0][RES_W-1:0] nar_sum;
    logic [RES_W-1:0] wide_sum0;
    logic [RES_W-1:0] wide_sum1;
    logic [RES_WORDS-1:0][RES_W-1:0] next_result;
    logic [LANES-1:0] next_flag;
    logic do_round;

    assign do_round = ctl_use[ADDSUB_W] && prod_q15;

    always_comb begin
        for (int k = 0; k < LANES; k++) begin
            nar_sum[k] = add_sub(prod_nar[2*k], prod_nar[2*k+1], ctl_use[k]);
        end
        wide_sum0 = add_sub(prod_wide[0], prod_wide[1], ctl_use[0]);
        wide_sum1 = add_sub(prod_wide[2], prod_wide[3], ctl_use[1]);
        next_flag = prod_sat;
        if (link.narrow_mode && link.four_mult_mode) begin
            next_result[0] = RES_W'(nar_sum[0] + nar_sum[1]);
            next_result[1] = RES_W'(nar_sum[2] + nar_sum[3]);
            next_flag = '0;
        end else if (link.narrow_mode) begin
            next_result[0] = {nar_sum[1][NAR_W-1:0], nar_sum[0][NAR_W-1:0]};
            next_result[1] = {nar_sum[3][NAR_W-1:0], nar_sum[2][NAR_W-1:0]};
            next_flag = '0;
        end else if (link.four_mult_mode) begin
            next_result[0] = RES_W'(wide_sum0 + wide_sum1);
            next_result[1] = '0;
        end else begin
            next_result[0] = wide_sum0;
            next_result[1] = wide_sum1;
        end
        if (do_round && !link.narrow_mode) begin
            next_result[0] = q15_round(next_result[0]);
            next_result[1] = q15_round(next_result[1]);
        end
    end

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            link.result <= '0;
            link.product_saturated_flag <= '0;
            link.result_valid <= 1'b0;
        end else begin
            link.result <= next_result;
            link.product_saturated_flag <= next_flag;
            link.result_valid <= prod_valid;
        end
    end
endmodule : dspma_device

// file: hdl/dspma_host.sv
// Fabric end: AHB-Lite slave registers that drive operands and controls
// into the multiply-add datapath and capture its results.
// Assumes one AHB-Lite master, single word transfers, the same hclk.
module dspma_host
    import dspma_pkg::*;
(
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link to datapath
    dspma_if.fab link
);
    logic [ADDR_W-1:0] dp_addr;
    logic dp_write;
    logic dp_read;
    logic wr_go;
    logic [CTRL_W-1:0] ctrl;
    logic done;
    logic [LANES-1:0] sat_seen;

    ////////////////////////////////////////////////////////////////////////////
    // Address phase capture
    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            dp_addr <= '0;
            dp_write <= 1'b0;
            dp_read <= 1'b0;
        end else if (hready) begin
            dp_addr <= haddr;
            dp_write <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            dp_read <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_go = dp_write && dp_addr == A_GO;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            ctrl <= CTRL_RST;
            link.shift_chain_in_a <= '0;
            link.oper_a <= '0;
            link.oper_b <= '0;
        end else if (dp_write) begin
            if (dp_addr == A_CTRL) begin
                ctrl <= hwdata[CTRL_W-1:0];
            end
            if (dp_addr == A_SHIFT) begin
                link.shift_chain_in_a <= hwdata[OP_W-1:0];
            end
            for (int k = 0; k < LANES; k++) begin
                if (dp_addr == A_OPA + ADDR_W'(4 * k)) begin
                    link.oper_a[k] <= hwdata[OP_W-1:0];
                end
                if (dp_addr == A_OPB + ADDR_W'(4 * k)) begin
                    link.oper_b[k] <= hwdata[OP_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            link.oper_valid <= 1'b0;
        end else begin
            link.oper_valid <= wr_go;
        end
    end

    assign link.narrow_mode = ctrl[CB_NARROW];
    assign link.four_mult_mode = ctrl[CB_FOUR];
    assign link.chain_enable = ctrl[CB_CHAIN];
    assign link.ctrl_reg_enable = ctrl[CB_CREG];
    assign link.ctl_pipe_two = ctrl[CB_PIPE2];
    assign link.sign_a = ctrl[CB_SIGNA];
    assign link.sign_b = ctrl[CB_SIGNB];
    assign link.saturate_enable = ctrl[CB_SAT];
    assign link.round_enable = ctrl[CB_ROUND];
    assign link.add_sub_select = ctrl[CB_ADDSUB +: ADDSUB_W];

    ////////////////////////////////////////////////////////////////////////////
    // Result capture; set wins over a GO clear
    logic [RES_WORDS-1:0][RES_W-1:0] res_hold;

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            res_hold <= '0;
            sat_seen <= '0;
            done <= 1'b0;
        end else if (link.result_valid) begin
            res_hold <= link.result;
            sat_seen <= link.product_saturated_flag;
            done <= 1'b1;
        end else if (wr_go) begin
            done <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        hrdata = '0;
        if (dp_read) begin
            case (dp_addr)
                A_CTRL: hrdata = 32'(ctrl);
                A_SHIFT: hrdata = 32'(link.shift_chain_out_a);
                A_STATUS: hrdata = 32'({sat_seen, done});
                A_RES: hrdata = res_hold[0][31:0];
                A_RES + 8'h04: hrdata = 32'(res_hold[0][RES_W-1:32]);
                A_RES + 8'h08: hrdata = res_hold[1][31:0];
                A_RES + 8'h0c: hrdata = 32'(res_hold[1][RES_W-1:32]);
                default: begin
                    for (int k = 0; k < LANES; k++) begin
                        if (dp_addr == A_OPA + ADDR_W'(4 * k)) begin
                            hrdata = 32'(link.oper_a[k]);
                        end
                        if (dp_addr == A_OPB + ADDR_W'(4 * k)) begin
                            hrdata = 32'(link.oper_b[k]);
                        end
                    end
                end
            endcase
        end
    end
endmodule : dspma_host

// file: dv/dspma_asserts.sv
// Checker on the link between the datapath and the fabric end.
// Assumes it sits beside the interface, on the same hclk and hresetn.
module dspma_asserts
    import dspma_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Fabric to datapath
    input wire logic [LANES-1:0][OP_W-1:0] oper_a,
    input wire logic [LANES-1:0][OP_W-1:0] oper_b,
    input wire logic oper_valid,
    input wire logic sign_a,
    input wire logic sign_b,
    input wire logic saturate_enable,
    input wire logic [ADDSUB_W-1:0] add_sub_select,
    input wire logic narrow_mode,
    input wire logic four_mult_mode,
    input wire logic chain_enable,
    input wire logic ctrl_reg_enable,
    input wire logic ctl_pipe_two,
    // Datapath to fabric
    input wire logic [RES_WORDS-1:0][RES_W-1:0] result,
    input wire logic result_valid,
    input wire logic [LANES-1:0] product_saturated_flag,
    input wire logic [OP_W-1:0] shift_chain_out_a
);
    localparam logic [OP_W-1:0] Q15_NEG_ONE = 18'h38000;
    logic neg_pair;
    assign neg_pair = oper_a[0] == Q15_NEG_ONE && oper_b[0] == Q15_NEG_ONE;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    function automatic logic [RES_W-1:0] um(input logic [OP_W-1:0] x, input logic [OP_W-1:0] y);
        return RES_W'(x) * RES_W'(y);
    endfunction : um

    ////////////////////////////////////////////////////////////////////////////
    sequence s_clamp_in;
        oper_valid && neg_pair ##1 sign_a && sign_b && saturate_enable && !narrow_mode;
    endsequence
    sequence s_uadd;
        oper_valid ##1 !narrow_mode && !four_mult_mode && !sign_a && !sign_b
        && !ctl_pipe_two && !ctrl_reg_enable;
    endsequence

    AST_RESULT_LATENCY: assert property (oper_valid |-> ##3 result_valid)
        else $error("no result_valid");
    AST_NO_PATH_WITHOUT_MULT: assert property (result_valid |-> $past(oper_valid, 3))
        else $error("result_valid unprompted");
    AST_UNSIGNED_PAIR: assert property (s_uadd |-> ##2 result[0] ==
        um($past(oper_a[0], 3), $past(oper_b[0], 3)) + ($past(add_sub_select[0], 2) ?
        -um($past(oper_a[1], 3), $past(oper_b[1], 3)) :
        um($past(oper_a[1], 3), $past(oper_b[1], 3))))
        else $error("pair result wrong");
    AST_FOUR_UPPER_ZERO: assert property (result_valid
        && $past(four_mult_mode && !narrow_mode, 3) |-> result[1] == '0)
        else $error("upper word not zero");
    AST_NARROW_NO_FLAG: assert property (narrow_mode && $past(narrow_mode, 3)
        |-> product_saturated_flag == '0) else $error("narrow flag");
    AST_CLAMP_FLAG: assert property (s_clamp_in
        |-> ##2 result_valid && product_saturated_flag[0]) else $error("clamp not flagged");
    AST_FLAG_ONLY_CLAMP: assert property (oper_valid && !neg_pair
        |-> ##3 !product_saturated_flag[0]) else $error("stray flag");
    AST_CHAIN_HOLD: assert property (!$past(oper_valid) |-> $stable(shift_chain_out_a))
        else $error("chain output moved");
    AST_PARALLEL_LOAD: assert property ($past(oper_valid) && !$past(chain_enable)
        |-> shift_chain_out_a == $past(oper_a[LANES-1])) else $error("load missed");
endmodule : dspma_asserts

// file: dv/test_dsp_multiply_add_datapath.sv
// Testbench: AHB-Lite register tests of the fabric end driving the datapath.
// Assumes package, interface, design ends and checker compiled first.
module test_dsp_multiply_add_datapath
    import dspma_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [LANES-1:0][OP_W-1:0] dspma_lanes_type;
    logic hclk, hresetn, hsel, hwrite, hready, hresp;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int tn = 0;

    dspma_if dspma_if_inst (.hclk(hclk), .hresetn(hresetn));
    dspma_device dspma_device_inst (.link(dspma_if_inst.dev));
    dspma_host dspma_host_inst (.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .link(dspma_if_inst.fab));
    dspma_asserts dspma_asserts_inst (.hclk(hclk), .hresetn(hresetn),
        .oper_a(dspma_if_inst.oper_a), .oper_b(dspma_if_inst.oper_b),
        .oper_valid(dspma_if_inst.oper_valid), .sign_a(dspma_if_inst.sign_a),
        .sign_b(dspma_if_inst.sign_b), .saturate_enable(dspma_if_inst.saturate_enable),
        .add_sub_select(dspma_if_inst.add_sub_select), .narrow_mode(dspma_if_inst.narrow_mode),
        .four_mult_mode(dspma_if_inst.four_mult_mode), .chain_enable(dspma_if_inst.chain_enable),
        .ctrl_reg_enable(dspma_if_inst.ctrl_reg_enable), .ctl_pipe_two(dspma_if_inst.ctl_pipe_two),
        .result(dspma_if_inst.result), .result_valid(dspma_if_inst.result_valid),
        .product_saturated_flag(dspma_if_inst.product_saturated_flag),
        .shift_chain_out_a(dspma_if_inst.shift_chain_out_a));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask : rd

    function automatic logic [RES_W-1:0] ext(input logic [RES_W-1:0] v, input int w, input logic s);
        logic [RES_W-1:0] m;
        m = (RES_W'(1) << w) - RES_W'(1);
        return (s && v[w-1]) ? (v | ~m) : (v & m);
    endfunction : ext

    task automatic calc(input logic [CTRL_W-1:0] c, input dspma_lanes_type a,
        input dspma_lanes_type b, output logic [RES_WORDS-1:0][RES_W-1:0] e,
        output logic [LANES-1:0] f);
        logic [RES_W-1:0] p [LANES];
        logic [RES_W-1:0] lo, hi;
        logic sa, sb, sq;
        sa = c[CB_SIGNA];
        sb = c[CB_SIGNB];
        sq = sa && sb && !c[CB_NARROW];
        f = '0;
        for (int k = 0; k < LANES; k++) begin
            lo = ext(RES_W'(a[k][8:0]), NAR_OP_W, sa) * ext(RES_W'(b[k][8:0]), NAR_OP_W, sb);
            hi = ext(RES_W'(a[k][17:9]), NAR_OP_W, sa) * ext(RES_W'(b[k][17:9]), NAR_OP_W, sb);
            if (c[CB_NARROW])
                p[k] = ext(c[CB_ADDSUB+k] ? lo - hi : lo + hi, NAR_W, 1'b1);
            else
                p[k] = ext(RES_W'(a[k]), OP_W, sa) * ext(RES_W'(b[k]), OP_W, sb);
            if (sq && c[CB_SAT] && p[k] == RES_W'(SAT_TRIP)) begin
                p[k] = RES_W'(SAT_MAX);
                f[k] = 1'b1;
            end
        end
        if (c[CB_NARROW] && !c[CB_FOUR]) begin
            e[0] = {p[1][NAR_W-1:0], p[0][NAR_W-1:0]};
            e[1] = {p[3][NAR_W-1:0], p[2][NAR_W-1:0]};
        end else if (c[CB_NARROW]) begin
            e[0] = p[0] + p[1];
            e[1] = p[2] + p[3];
        end else begin
            e[0] = c[CB_ADDSUB] ? p[0] - p[1] : p[0] + p[1];
            e[1] = c[CB_ADDSUB+1] ? p[2] - p[3] : p[2] + p[3];
            if (c[CB_FOUR]) begin
                e[0] = e[0] + e[1];
                e[1] = '0;
            end
            if (sq && c[CB_ROUND])
                for (int k = 0; k < RES_WORDS; k++)
                    e[k] = (e[k] + ROUND_HALF) & ROUND_MASK;
        end
    endtask : calc

    // One operation: set up, start, wait, compare
    task automatic run(input logic [CTRL_W-1:0] c, input dspma_lanes_type a,
        input dspma_lanes_type b);
        logic [RES_WORDS-1:0][RES_W-1:0] e;
        logic [LANES-1:0] f;
        logic [31:0] d;
        int n;
        wr(A_CTRL, 32'(c));
        for (int k = 0; k < LANES; k++) begin
            wr(A_OPB + ADDR_W'(4 * k), 32'(b[k]));
            if (!c[CB_CHAIN])
                wr(A_OPA + ADDR_W'(4 * k), 32'(a[k]));
        end
        if (c[CB_CHAIN]) begin
            for (int k = LANES - 1; k >= 0; k--) begin
                wr(A_SHIFT, 32'(a[k]));
                wr(A_GO, 32'h0);
                repeat (4) @(posedge hclk);
            end
        end else
            wr(A_GO, 32'h0);
        n = 0;
        d = '0;
        while (d[SB_DONE] !== 1'b1 && n < 50) begin
            rd(A_STATUS, d);
            n++;
        end
        calc(c, a, b, e, f);
        chk("done", 64'h1, 64'(d[SB_DONE]));
        chk("flags", 64'(f), 64'(d[SB_SAT+:LANES]));
        for (int k = 0; k < RES_WORDS; k++) begin
            rd(A_RES + ADDR_W'(8 * k), d);
            chk("result_low", 64'(e[k][31:0]), 64'(d));
            rd(A_RES + ADDR_W'(8 * k + 4), d);
            chk("result_high", 64'(e[k][RES_W-1:32]), 64'(d[RES_W-33:0]));
        end
        if (c[CB_CHAIN]) begin
            rd(A_SHIFT, d);
            chk("chain_out", 64'(a[LANES-1]), 64'(d[OP_W-1:0]));
        end
        tn++;
        $display("test %0d done", tn);
    endtask : run

    initial begin
        logic [31:0] d;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        hresetn = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(A_CTRL, d);
        chk("ctrl_reset", 64'(CTRL_RST), 64'(d));
        rd(A_STATUS, d);
        chk("status_reset", 64'h0, 64'(d));
        wr(8'hfc, 32'hffffffff);
        rd(8'hfc, d);
        chk("unmapped", 64'h0, 64'(d));
        chk("hresp", 64'h0, 64'(hresp));
        run(13'h0, {18'h10, 18'h7, 18'h3ffff, 18'h3}, {18'h2, 18'h9, 18'h5, 18'h3ffff});
        run(13'h200, {18'h10, 18'h7, 18'h3ffff, 18'h3},
            {18'h2, 18'h9, 18'h5, 18'h3ffff});
        run(13'h260, {18'h3fffe, 18'h3, 18'h3fffe, 18'h3},
            {18'h5, 18'h3fffc, 18'h3fffc, 18'h5});
        run(13'h428, {18'h3ff00, 18'h41, 18'h20000, 18'h3fff1},
            {18'h3ffff, 18'h7, 18'h3, 18'h1f});
        run(13'h272, {18'h3fff0, 18'h123, 18'h1ffff, 18'h5},
            {18'h3, 18'h3fffb, 18'h1ffff, 18'h7});
        run(13'h1401, {18'h3fe01, 18'h1ff, 18'hc05, 18'h403},
            {18'h3fe02, 18'h1ff, 18'ha07, 18'h609});
        run(13'h63, {18'h3fe01, 18'h1ff, 18'hc05, 18'h3fffe},
            {18'h3fe02, 18'h1ff, 18'ha07, 18'h609});
        run(13'he0, {18'h5, 18'h38000, 18'h7, 18'h38000},
            {18'h3, 18'h4000, 18'h9, 18'h38000});
        run(13'h1f8, {18'h38000, 18'h38000, 18'h7, 18'h38000},
            {18'h3, 18'h38000, 18'h9, 18'h38000});
        run(13'h1e1, {LANES{18'h38000}}, {LANES{18'h38000}});
        run(13'h180, {LANES{18'h38000}}, {LANES{18'h38000}});
        run(13'h66, {18'h11, 18'h3fff2, 18'h33, 18'h44},
            {18'h1, 18'h3fffe, 18'h3, 18'h4});
        end_sim();
    end
endmodule : test_dsp_multiply_add_datapath
